// ==== hdl/emm_pkg.sv ====
// Constants, types and helper functions of the emulation memory mapper.
// Assumes a 24-bit processor address and a 32-bit AHB-Lite register bus.
package emm_pkg;

    // ********************************
    // Sizes
    // ********************************
    localparam int unsigned EMM_ENTRIES = 8;
    localparam int unsigned EMM_IDX_W = 3;
    localparam int unsigned EMM_ADDR_W = 24;
    localparam int unsigned EMM_PAGE_W = 16;
    localparam int unsigned EMM_BLOCKS = 8;
    localparam int unsigned EMM_BLK_W = 3;
    localparam int unsigned EMM_EMU_ADDR_W = 19;
    localparam int unsigned EMM_ST_W = 3;

    // ********************************
    // Register offsets and fields
    // ********************************
    localparam logic [11:0] EMM_OFF_CTRL = 12'h000;
    localparam logic [11:0] EMM_OFF_STATUS = 12'h004;
    localparam logic [11:0] EMM_OFF_MASK = 12'h008;
    localparam logic [11:0] EMM_OFF_ALLOC = 12'h00C;
    localparam logic [11:0] EMM_OFF_ENTRY = 12'h020;
    localparam logic [11:0] EMM_OFF_ENTRY_END = 12'h060;
    localparam int unsigned EMM_CTRL_BRK = 0;
    localparam int unsigned EMM_CTRL_TRACE = 1;
    localparam int unsigned EMM_CTRL_DFLT = 4;
    localparam int unsigned EMM_ENT_VALID = 31;
    localparam int unsigned EMM_CFG_TYPE = 16;
    localparam int unsigned EMM_CFG_QUAL = 20;
    localparam int unsigned EMM_ST_ROM = 0;
    localparam int unsigned EMM_ST_GUARD = 1;
    localparam int unsigned EMM_ST_ALLOC = 2;
    localparam logic [1:0] EMM_DFLT_RST = 2'h0;
    localparam logic [1:0] EMM_DFLT_BAD = 2'h3;
    localparam logic [EMM_ST_W-1:0] EMM_ST_RST = 3'h0;

    // ********************************
    // Types
    // ********************************
    typedef enum logic [2:0] {
        EMM_EMU_RAM = 3'h0,
        EMM_EMU_ROM = 3'h1,
        EMM_TGT_RAM = 3'h2,
        EMM_TGT_ROM = 3'h3,
        EMM_GUARD = 3'h4
    } emm_mem_type;

    typedef enum logic [3:0] {
        EMM_Q_NONE = 4'h0,
        EMM_Q_SUP = 4'h1,
        EMM_Q_SUP_PROG = 4'h2,
        EMM_Q_SUP_DATA = 4'h3,
        EMM_Q_USER = 4'h4,
        EMM_Q_USER_PROG = 4'h5,
        EMM_Q_USER_DATA = 4'h6,
        EMM_Q_PROG = 4'h7,
        EMM_Q_DATA = 4'h8
    } emm_qual_type;

    typedef enum logic [1:0] {
        EMM_TR_BOTH = 2'h0,
        EMM_TR_FG = 2'h1,
        EMM_TR_BG = 2'h2
    } emm_trace_type;

    typedef enum logic [1:0] {
        EMM_AHB_IDLE = 2'h0,
        EMM_AHB_WRITE = 2'h1,
        EMM_AHB_READ = 2'h3
    } emm_ahb_state_type;

    localparam logic [2:0] EMM_FC_UD = 3'h1;
    localparam logic [2:0] EMM_FC_UP = 3'h2;
    localparam logic [2:0] EMM_FC_SD = 3'h5;
    localparam logic [2:0] EMM_FC_SP = 3'h6;

    // ********************************
    // Functions
    // ********************************
    function automatic logic emm_fc_match(input logic [3:0] qual, input logic [2:0] fc);
        logic sup;
        logic usr;
        logic prg;
        logic dat;
        sup = (fc == EMM_FC_SD) || (fc == EMM_FC_SP);
        usr = (fc == EMM_FC_UD) || (fc == EMM_FC_UP);
        prg = (fc == EMM_FC_UP) || (fc == EMM_FC_SP);
        dat = (fc == EMM_FC_UD) || (fc == EMM_FC_SD);
        case (qual)
            EMM_Q_NONE: emm_fc_match = 1'b1;
            EMM_Q_SUP: emm_fc_match = sup;
            EMM_Q_SUP_PROG: emm_fc_match = sup && prg;
            EMM_Q_SUP_DATA: emm_fc_match = sup && dat;
            EMM_Q_USER: emm_fc_match = usr;
            EMM_Q_USER_PROG: emm_fc_match = usr && prg;
            EMM_Q_USER_DATA: emm_fc_match = usr && dat;
            EMM_Q_PROG: emm_fc_match = prg;
            EMM_Q_DATA: emm_fc_match = dat;
            default: emm_fc_match = 1'b0;
        endcase
    endfunction : emm_fc_match

    function automatic emm_mem_type emm_dflt_type(input logic [1:0] code);
        case (code)
            2'h1: emm_dflt_type = EMM_TGT_ROM;
            2'h2: emm_dflt_type = EMM_GUARD;
            default: emm_dflt_type = EMM_TGT_RAM;
        endcase
    endfunction : emm_dflt_type

endpackage : emm_pkg

// ==== hdl/emm_match_if.sv ====
// Carrier between the mapper and its region matcher.
// Assumes the mapper drives the cycle and entry table, the matcher answers.
`timescale 1ns/1ps
interface emm_match_if;
    import emm_pkg::*;
    logic [EMM_ADDR_W-1:0] cyc_addr;
    logic [2:0] cyc_fc;
    logic [EMM_PAGE_W-1:0] ent_start [EMM_ENTRIES];
    logic [EMM_PAGE_W-1:0] ent_end [EMM_ENTRIES];
    logic [2:0] ent_type [EMM_ENTRIES];
    logic [3:0] ent_qual [EMM_ENTRIES];
    logic [EMM_ENTRIES-1:0] ent_ok;
    logic [EMM_BLK_W-1:0] ent_blk [EMM_ENTRIES];
    logic hit;
    logic [2:0] mtype;
    logic [EMM_EMU_ADDR_W-1:0] emu_addr;

    modport mapper (output cyc_addr, cyc_fc, ent_start, ent_end, ent_type, ent_qual, ent_ok,
        ent_blk, input hit, mtype, emu_addr);
    modport matcher (input cyc_addr, cyc_fc, ent_start, ent_end, ent_type, ent_qual, ent_ok,
        ent_blk, output hit, mtype, emu_addr);
endinterface : emm_match_if

// ==== hdl/emm_region_match.sv ====
// Region matcher: finds the first enabled entry covering a bus cycle.
// Assumes a combinational path; the caller registers the result.
`timescale 1ns/1ps
module emm_region_match
    import emm_pkg::*;
(
    emm_match_if.matcher m
);

    // ********************************
    // Match
    // ********************************
    always_comb begin
        logic [EMM_PAGE_W-1:0] page;
        logic [EMM_ADDR_W-1:0] offset;
        logic [EMM_BLK_W-1:0] blk;
        page = m.cyc_addr[EMM_ADDR_W-1:8];
        offset = '0;
        blk = '0;
        m.hit = 1'b0;
        m.mtype = EMM_TGT_RAM;
        m.emu_addr = '0;
        // Highest index first, so the lowest matching entry wins
        for (int i = EMM_ENTRIES - 1; i >= 0; i--) begin
            if (m.ent_ok[i] && page >= m.ent_start[i] && page <= m.ent_end[i] &&
                emm_fc_match(m.ent_qual[i], m.cyc_fc)) begin
                offset = m.cyc_addr - {m.ent_start[i], 8'h00};
                blk = m.ent_blk[i] + offset[18:16];
                m.hit = 1'b1;
                m.mtype = m.ent_type[i];
                m.emu_addr = {blk, offset[15:0]};
            end
        end
        // No hit leaves the default type to the caller
    end

endmodule : emm_region_match

// ==== hdl/emm_mapper.sv ====
// Emulation memory mapper top: AHB-Lite registers, cycle classifier, breaks.
// Assumes the processor bus is synchronous to hclk and one cycle wide.
//
// The placing of the registers and the AHB-Lite slave port were chosen for this implementation.
`timescale 1ns/1ps
module emm_mapper
    import emm_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    input wire logic cyc_valid,
    input wire logic [EMM_ADDR_W-1:0] cyc_addr,
    input wire logic cyc_write,
    input wire logic function_code_bit0,
    input wire logic function_code_bit1,
    input wire logic function_code_bit2,
    input wire logic cyc_background,
    output logic emu_sel,
    output logic emu_we,
    output logic [EMM_EMU_ADDR_W-1:0] emu_addr,
    output logic tgt_sel,
    output logic tgt_we,
    output logic [EMM_ADDR_W-1:0] tgt_addr,
    output logic break_req,
    output logic trace_valid,
    output logic irq
);

    // ********************************
    // Register state
    // ********************************
    emm_ahb_state_type state_q, state_d;
    logic [11:0] addr_q, addr_d;
    logic hready_q, hready_d;
    logic [31:0] rdata_q, rdata_d;
    logic brk_en_q, brk_en_d;
    logic [1:0] trace_q, trace_d;
    logic [1:0] dflt_q, dflt_d;
    logic [EMM_ST_W-1:0] status_q, status_d;
    logic [EMM_ST_W-1:0] mask_q, mask_d;
    logic [EMM_ENTRIES-1:0] valid_q, valid_d;
    logic [EMM_PAGE_W-1:0] start_q [EMM_ENTRIES];
    logic [EMM_PAGE_W-1:0] start_d [EMM_ENTRIES];
    logic [EMM_PAGE_W-1:0] end_q [EMM_ENTRIES];
    logic [EMM_PAGE_W-1:0] end_d [EMM_ENTRIES];
    logic [2:0] type_q [EMM_ENTRIES];
    logic [2:0] type_d [EMM_ENTRIES];
    logic [3:0] qual_q [EMM_ENTRIES];
    logic [3:0] qual_d [EMM_ENTRIES];
    logic [EMM_ST_W-1:0] st_set;
    logic [9:0] blocks_used;
    logic alloc_over;
    logic [EMM_ENTRIES-1:0] ent_ok;
    logic [EMM_BLK_W-1:0] ent_blk [EMM_ENTRIES];

    emm_match_if mif ();

    emm_region_match u_match (
        .m(mif.matcher)
    );

    // ********************************
    // Block allocation
    // ********************************
    always_comb begin
        logic [9:0] run;
        logic [9:0] need;
        logic emu;
        run = '0;
        need = '0;
        emu = 1'b0;
        alloc_over = 1'b0;
        // Rebuilt from the table every cycle, so any edit of a range, type or valid bit may move blocks
        for (int i = 0; i < EMM_ENTRIES; i++) begin
            emu = (type_q[i] == EMM_EMU_RAM) || (type_q[i] == EMM_EMU_ROM);
            need = {2'b00, 8'(({16'h0000, end_q[i]} - {16'h0000, start_q[i]}) >> 8)} + 10'h001;
            ent_blk[i] = run[EMM_BLK_W-1:0];
            ent_ok[i] = valid_q[i] && (end_q[i] >= start_q[i]);
            if (ent_ok[i] && emu) begin
                run = run + need;
                if (run > 10'(EMM_BLOCKS)) begin
                    ent_ok[i] = 1'b0;
                    alloc_over = 1'b1;
                end
            end
        end
        blocks_used = run;
    end

    always_comb begin
        mif.cyc_addr = cyc_addr;
        mif.cyc_fc = {function_code_bit2, function_code_bit1, function_code_bit0};
        mif.ent_start = start_q;
        mif.ent_end = end_q;
        mif.ent_type = type_q;
        mif.ent_qual = qual_q;
        mif.ent_ok = ent_ok;
        mif.ent_blk = ent_blk;
    end

    // ********************************
    // AHB-Lite slave
    // ********************************
    function automatic logic [31:0] emm_read(input logic [11:0] a);
        logic [11:0] rel;
        logic [EMM_IDX_W-1:0] idx;
        rel = a - EMM_OFF_ENTRY;
        idx = rel[5:3];
        emm_read = 32'h0000_0000;
        if (a == EMM_OFF_CTRL) begin
            emm_read = {26'h0, dflt_q, 1'b0, trace_q, brk_en_q};
        end else if (a == EMM_OFF_STATUS) begin
            emm_read = {29'h0, status_q};
        end else if (a == EMM_OFF_MASK) begin
            emm_read = {29'h0, mask_q};
        end else if (a == EMM_OFF_ALLOC) begin
            emm_read = {22'h0, blocks_used};
        end else if (a >= EMM_OFF_ENTRY && a < EMM_OFF_ENTRY_END) begin
            if (rel[2]) begin
                emm_read = {8'h00, qual_q[idx], 1'b0, type_q[idx], end_q[idx]};
            end else begin
                emm_read = {valid_q[idx], 15'h0000, start_q[idx]};
            end
        end
    endfunction : emm_read

    always_comb begin
        logic [11:0] rel;
        logic [EMM_IDX_W-1:0] idx;
        logic [EMM_ST_W-1:0] w1c;
        rel = addr_q - EMM_OFF_ENTRY;
        idx = rel[5:3];
        w1c = '0;
        state_d = EMM_AHB_IDLE;
        addr_d = addr_q;
        hready_d = 1'b1;
        rdata_d = rdata_q;
        brk_en_d = brk_en_q;
        trace_d = trace_q;
        dflt_d = dflt_q;
        mask_d = mask_q;
        valid_d = valid_q;
        start_d = start_q;
        end_d = end_q;
        type_d = type_q;
        qual_d = qual_q;
        case (state_q)
            EMM_AHB_WRITE: begin
                if (addr_q == EMM_OFF_CTRL) begin
                    brk_en_d = hwdata[EMM_CTRL_BRK];
                    trace_d = hwdata[EMM_CTRL_TRACE+:2];
                    if (hwdata[EMM_CTRL_DFLT+:2] != EMM_DFLT_BAD) begin
                        dflt_d = hwdata[EMM_CTRL_DFLT+:2];
                    end
                end else if (addr_q == EMM_OFF_STATUS) begin
                    w1c = hwdata[EMM_ST_W-1:0];
                end else if (addr_q == EMM_OFF_MASK) begin
                    mask_d = hwdata[EMM_ST_W-1:0];
                end else if (addr_q >= EMM_OFF_ENTRY && addr_q < EMM_OFF_ENTRY_END) begin
                    if (rel[2]) begin
                        end_d[idx] = hwdata[EMM_PAGE_W-1:0];
                        type_d[idx] = hwdata[EMM_CFG_TYPE+:3];
                        qual_d[idx] = hwdata[EMM_CFG_QUAL+:4];
                    end else begin
                        start_d[idx] = hwdata[EMM_PAGE_W-1:0];
                        valid_d[idx] = hwdata[EMM_ENT_VALID];
                    end
                end
            end
            EMM_AHB_READ: begin
                rdata_d = emm_read(addr_q);
            end
            default: begin
            end
        endcase
        if (hsel && htrans[1] && hready) begin
            addr_d = haddr[11:0];
            if (hwrite) begin
                state_d = EMM_AHB_WRITE;
            end else begin
                state_d = EMM_AHB_READ;
                hready_d = 1'b0;
            end
        end
        // Hardware set wins over a same-cycle clear
        status_d = (status_q & ~w1c) | st_set;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_q <= EMM_AHB_IDLE;
            addr_q <= 12'h000;
            hready_q <= 1'b1;
            rdata_q <= 32'h0000_0000;
            brk_en_q <= 1'b0;
            trace_q <= EMM_TR_BOTH;
            dflt_q <= EMM_DFLT_RST;
            status_q <= EMM_ST_RST;
            mask_q <= EMM_ST_RST;
            valid_q <= '0;
            for (int i = 0; i < EMM_ENTRIES; i++) begin
                start_q[i] <= 16'h0000;
                end_q[i] <= 16'h0000;
                type_q[i] <= EMM_TGT_RAM;
                qual_q[i] <= EMM_Q_NONE;
            end
        end else begin
            state_q <= state_d;
            addr_q <= addr_d;
            hready_q <= hready_d;
            rdata_q <= rdata_d;
            brk_en_q <= brk_en_d;
            trace_q <= trace_d;
            dflt_q <= dflt_d;
            status_q <= status_d;
            mask_q <= mask_d;
            valid_q <= valid_d;
            start_q <= start_d;
            end_q <= end_d;
            type_q <= type_d;
            qual_q <= qual_d;
        end
    end

    // ********************************
    // Cycle classification
    // ********************************
    logic emu_sel_q, emu_sel_d, emu_we_q, emu_we_d, tgt_sel_q, tgt_sel_d, tgt_we_q, tgt_we_d;
    logic brk_q, brk_d, trv_q, trv_d, irq_q, irq_d;
    logic [EMM_EMU_ADDR_W-1:0] emu_addr_q, emu_addr_d;
    logic [EMM_ADDR_W-1:0] tgt_addr_q, tgt_addr_d;
    logic [2:0] eff_type;
    logic is_rom;
    logic is_guard;

    always_comb begin
        eff_type = mif.hit ? mif.mtype : emm_dflt_type(dflt_q);
        is_rom = (eff_type == EMM_EMU_ROM) || (eff_type == EMM_TGT_ROM);
        is_guard = !(eff_type inside {EMM_EMU_RAM, EMM_EMU_ROM, EMM_TGT_RAM, EMM_TGT_ROM});
        emu_sel_d = cyc_valid && (eff_type == EMM_EMU_RAM || eff_type == EMM_EMU_ROM);
        emu_we_d = cyc_valid && cyc_write && (eff_type == EMM_EMU_RAM);
        tgt_sel_d = cyc_valid && !emu_sel_d;
        tgt_we_d = cyc_valid && cyc_write && !emu_sel_d;
        emu_addr_d = mif.emu_addr;
        tgt_addr_d = cyc_addr;
        st_set = '0;
        st_set[EMM_ST_ROM] = cyc_valid && cyc_write && is_rom && !cyc_background &&
            brk_en_q;
        st_set[EMM_ST_GUARD] = cyc_valid && is_guard;
        st_set[EMM_ST_ALLOC] = alloc_over;
        brk_d = st_set[EMM_ST_ROM] || st_set[EMM_ST_GUARD];
        case (trace_q)
            EMM_TR_FG: trv_d = cyc_valid && !cyc_background;
            EMM_TR_BG: trv_d = cyc_valid && cyc_background;
            default: trv_d = cyc_valid;
        endcase
        irq_d = |(status_q & mask_q);
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            emu_sel_q <= 1'b0;
            emu_we_q <= 1'b0;
            tgt_sel_q <= 1'b0;
            tgt_we_q <= 1'b0;
            emu_addr_q <= '0;
            tgt_addr_q <= '0;
            brk_q <= 1'b0;
            trv_q <= 1'b0;
            irq_q <= 1'b0;
        end else begin
            emu_sel_q <= emu_sel_d;
            emu_we_q <= emu_we_d;
            tgt_sel_q <= tgt_sel_d;
            tgt_we_q <= tgt_we_d;
            emu_addr_q <= emu_addr_d;
            tgt_addr_q <= tgt_addr_d;
            brk_q <= brk_d;
            trv_q <= trv_d;
            irq_q <= irq_d;
        end
    end

    assign hreadyout = hready_q;
    assign hrdata = rdata_q;
    assign hresp = 1'b0;
    assign emu_sel = emu_sel_q;
    assign emu_we = emu_we_q;
    assign emu_addr = emu_addr_q;
    assign tgt_sel = tgt_sel_q;
    assign tgt_we = tgt_we_q;
    assign tgt_addr = tgt_addr_q;
    assign break_req = brk_q;
    assign trace_valid = trv_q;
    assign irq = irq_q;

    // ********************************
    // Assertions
    // ********************************
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    a_default_target: assert property (cyc_valid && !mif.hit && dflt_q == 2'h0
        |=> tgt_sel && !emu_sel) else $error("unmapped cycle not sent to target");
    a_default_not_emu: assert property (dflt_q != EMM_DFLT_BAD)
        else $error("default type holds a forbidden code");
    a_fc_select: assert property (cyc_valid && mif.hit && mif.mtype == EMM_EMU_RAM
        |=> emu_sel && emu_addr == $past(mif.emu_addr)) else $error("region block not selected");
    a_emu_rom_nowrite: assert property (cyc_valid && cyc_write && eff_type == EMM_EMU_ROM
        |=> emu_sel && !emu_we) else $error("emulation ROM written");
    a_rom_break: assert property (cyc_valid && cyc_write && is_rom && !cyc_background
        && brk_en_q |=> break_req ##1 status_q[EMM_ST_ROM]) else $error("ROM write break missing");
    a_tgt_rom_pass: assert property (cyc_valid && cyc_write && eff_type == EMM_TGT_ROM
        |=> tgt_sel && tgt_we && tgt_addr == $past(cyc_addr)) else $error("target ROM write lost");
    a_rom_nobreak: assert property (cyc_valid && is_rom && !brk_en_q |=> !break_req)
        else $error("break with ROM break disabled");
    a_trace_mode: assert property (cyc_valid && trace_q == EMM_TR_FG && cyc_background
        |=> !trace_valid) else $error("background cycle traced in foreground mode");
    a_page_offset: assert property (cyc_valid && mif.hit |=> emu_addr[7:0] == tgt_addr[7:0])
        else $error("page offset not kept");
    a_block_bound: assert property (!alloc_over |-> blocks_used <= 10'(EMM_BLOCKS))
        else $error("blocks overcommitted");
    a_guard_break: assert property (cyc_valid && eff_type == EMM_GUARD
        |=> break_req && tgt_sel) else $error("guarded access without break");
    a_read_wait: assert property (hsel && htrans[1] && hready && !hwrite
        |=> !hreadyout ##1 hreadyout) else $error("read answer timing wrong");
    a_irq_level: assert property (|(status_q & mask_q) |=> irq)
        else $error("interrupt not raised");

    c_rom_break: cover property (cyc_valid && cyc_write && is_rom && brk_en_q ##1 break_req);
    c_guard: cover property (cyc_valid && is_guard);
    c_overlap: cover property (cyc_valid && mif.hit && mif.mtype == EMM_EMU_RAM
        && mif.cyc_fc == EMM_FC_UD);
    c_irq: cover property (irq ##1 !irq);

endmodule : emm_mapper

// ==== testbench/emm_cpu_model.sv ====
// Processor bus model issuing one function-coded cycle per request.
// Assumes the mapper samples the strobe at the rising edge of hclk.
`timescale 1ns/1ps
module emm_cpu_model
    import emm_pkg::*;
(
    input wire logic hclk,
    output logic cyc_valid,
    output logic [EMM_ADDR_W-1:0] cyc_addr,
    output logic cyc_write,
    output logic [2:0] fc,
    output logic cyc_background
);
    logic busy = 1'b0;
    initial begin
        cyc_valid = 1'b0;
        cyc_addr = '0;
        cyc_write = 1'b0;
        fc = 3'h0;
        cyc_background = 1'b0;
    end
    // Idle address lines wander
    always @(posedge hclk) begin
        if (!busy) begin
            cyc_addr <= ~cyc_addr;
        end
    end
    task automatic run(input logic [23:0] a, input logic w, input logic [2:0] f, input logic bg);
        busy = 1'b1;
        @(posedge hclk);
        cyc_valid <= 1'b1;
        cyc_addr <= a;
        cyc_write <= w;
        fc <= f;
        cyc_background <= bg;
        @(posedge hclk);
        cyc_valid <= 1'b0;
        busy = 1'b0;
        #1;
    endtask : run
endmodule : emm_cpu_model

// ==== testbench/emm_mapper_test.sv ====
// Self-checking bench of the mapper: registers, mapping, breaks, trace, irq.
// Assumes the processor bus model drives the cycle strobe.
`timescale 1ns/1ps
module emm_mapper_test;
    import emm_pkg::*;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = '0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = '0;
    logic hreadyout, hresp, cyc_valid, cyc_write, cyc_background, emu_sel, emu_we;
    logic tgt_sel, tgt_we, break_req, trace_valid, irq;
    logic [31:0] hrdata;
    logic [2:0] fc;
    logic [23:0] cyc_addr, tgt_addr;
    logic [18:0] emu_addr;
    logic [4:0] o5;
    logic [31:0] rnd = 32'h42;
    int num_errors = 0;
    int n_checks = 0;
    assign o5 = {emu_sel, emu_we, tgt_sel, tgt_we, break_req};
    initial begin
        forever #25 hclk = ~hclk;
    end
    emm_mapper dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .cyc_valid(cyc_valid),
        .cyc_addr(cyc_addr), .cyc_write(cyc_write), .function_code_bit0(fc[0]),
        .function_code_bit1(fc[1]), .function_code_bit2(fc[2]),
        .cyc_background(cyc_background), .emu_sel(emu_sel), .emu_we(emu_we),
        .emu_addr(emu_addr), .tgt_sel(tgt_sel), .tgt_we(tgt_we), .tgt_addr(tgt_addr),
        .break_req(break_req), .trace_valid(trace_valid), .irq(irq));
    emm_cpu_model cpu_u (.hclk(hclk), .cyc_valid(cyc_valid), .cyc_addr(cyc_addr),
        .cyc_write(cyc_write), .fc(fc), .cyc_background(cyc_background));
    function automatic logic [31:0] xs(input logic [31:0] x);
        logic [31:0] y;
        y = x ^ (x << 13);
        y = y ^ (y >> 17);
        xs = y ^ (y << 5);
    endfunction : xs
    // Expected qualifier match
    function automatic logic qm(input int q, input logic [2:0] f);
        logic s, u, p, d;
        s = f == 3'h5 || f == 3'h6;
        u = f == 3'h1 || f == 3'h2;
        p = f == 3'h2 || f == 3'h6;
        d = f == 3'h1 || f == 3'h5;
        case (q)
            0: qm = 1'b1;
            1: qm = s;
            2: qm = s && p;
            3: qm = s && d;
            4: qm = u;
            5: qm = u && p;
            6: qm = u && d;
            7: qm = p;
            default: qm = d;
        endcase
    endfunction : qm
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("[FAIL] %0t saw %h want %h", $time, seen, exp);
        end
    endtask : chk
    task automatic stop_test;
        $display("checks %0d mismatches %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : stop_test
    task automatic rdy;
        int n;
        n = 0;
        #1;
        while (hreadyout !== 1'b1) begin
            n++;
            if (n > 20) begin
                chk(32'h0, 32'h1);
                stop_test;
            end
            @(posedge hclk);
            #1;
        end
        @(posedge hclk);
    endtask : rdy
    task automatic ahb(input logic w, input logic [11:0] a, input logic [31:0] d,
        output logic [31:0] r);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {20'h0, a};
        rdy;
        htrans <= 2'h0;
        hwdata <= d;
        rdy;
        r = hrdata;
    endtask : ahb
    initial begin
        logic [31:0] r;
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        for (int i = 0; i < 5; i++) begin
            ahb(1'b0, 12'(i * 4), 32'h0, r);
            chk(r, 32'h0);
        end
        ahb(1'b1, 12'h010, 32'hFFFF, r);
        ahb(1'b0, 12'h010, 32'h0, r);
        chk(r, 32'h0);
        chk(32'(hresp), 32'h0);
        $display("registers done");
        cpu_u.run(24'h123456, 1'b1, 3'h1, 1'b0);
        chk(32'(o5), 32'h06);
        ahb(1'b1, 12'h000, 32'h20, r);
        cpu_u.run(24'h123456, 1'b0, 3'h1, 1'b1);
        chk(32'(o5), 32'h05);
        ahb(1'b1, 12'h000, 32'h30, r);
        ahb(1'b0, 12'h000, 32'h0, r);
        chk(r, 32'h20);
        ahb(1'b1, 12'h000, 32'h11, r);
        cpu_u.run(24'h123456, 1'b1, 3'h1, 1'b0);
        chk(32'(o5), 32'h07);
        $display("default done");
        ahb(1'b1, 12'h020, 32'h80000010, r);
        ahb(1'b1, 12'h024, 32'h0021001F, r);
        ahb(1'b1, 12'h028, 32'h80000010, r);
        ahb(1'b1, 12'h02C, 32'h0060001F, r);
        ahb(1'b1, 12'h030, 32'h80000040, r);
        ahb(1'b1, 12'h034, 32'h0003004F, r);
        ahb(1'b0, 12'h00C, 32'h0, r);
        chk(r, 32'h2);
        cpu_u.run(24'h001234, 1'b1, 3'h6, 1'b0);
        chk(32'(o5), 32'h11);
        chk(32'(emu_addr), 32'h00234);
        cpu_u.run(24'h001234, 1'b1, 3'h1, 1'b0);
        chk(32'(o5), 32'h18);
        chk(32'(emu_addr), 32'h10234);
        cpu_u.run(24'h001234, 1'b0, 3'h2, 1'b0);
        chk(32'(o5), 32'h04);
        cpu_u.run(24'h004100, 1'b1, 3'h5, 1'b0);
        chk(32'(o5), 32'h07);
        chk(32'(tgt_addr), 32'h004100);
        ahb(1'b1, 12'h000, 32'h10, r);
        cpu_u.run(24'h001234, 1'b1, 3'h6, 1'b0);
        chk(32'(o5), 32'h10);
        $display("mapping done");
        ahb(1'b1, 12'h008, 32'h1, r);
        repeat (2) @(posedge hclk);
        #1;
        chk(32'(irq), 32'h1);
        ahb(1'b1, 12'h004, 32'h1, r);
        ahb(1'b0, 12'h004, 32'h0, r);
        chk(r, 32'h2);
        chk(32'(irq), 32'h0);
        $display("interrupt done");
        for (int m = 0; m < 3; m++) begin
            ahb(1'b1, 12'h000, 32'(m * 2), r);
            for (int b = 0; b < 2; b++) begin
                cpu_u.run(24'h123456, 1'b0, 3'h1, b[0]);
                chk(32'(trace_valid), 32'(m == 0 || (m == 1 && b == 0) || (m == 2 && b == 1)));
            end
        end
        $display("trace done");
        ahb(1'b1, 12'h038, 32'h80000800, r);
        for (int q = 0; q < 9; q++) begin
            ahb(1'b1, 12'h03C, 32'h0004080F | (q << 20), r);
            for (int k = 0; k < 4; k++) begin
                rnd = xs(rnd);
                cpu_u.run({12'h080, rnd[11:0]}, rnd[12], rnd[15:13], rnd[16]);
                chk(32'(break_req), 32'(qm(q, rnd[15:13])));
            end
            cpu_u.run(24'h081000, 1'b0, 3'h6, 1'b0);
            chk(32'(break_req), 32'h0);
        end
        $display("qualifier done");
        ahb(1'b1, 12'h040, 32'h80001000, r);
        ahb(1'b1, 12'h044, 32'h000017FF, r);
        ahb(1'b0, 12'h004, 32'h0, r);
        chk(32'(r[2]), 32'h1);
        cpu_u.run(24'h101000, 1'b1, 3'h1, 1'b0);
        chk(32'(o5), 32'h06);
        $display("allocation done");
        stop_test;
    end
endmodule : emm_mapper_test
